/* File: fiap_core.sv */
`timescale 1ns/1ps

module fiap_core #(
  parameter int ERASE_FAST = fiap_pkg::ERASE_FAST_CYCLES,
  parameter int ERASE_SLOW = fiap_pkg::ERASE_SLOW_CYCLES,
  parameter int WRITE_FAST = fiap_pkg::WRITE_FAST_CYCLES,
  parameter int WRITE_SLOW = fiap_pkg::WRITE_SLOW_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] flash_buf_idx,
  output logic [15:0] flash_buf_data,
  output logic [31:0] flash_tags,
  output logic [8:0] flash_page,
  output logic flash_erase,
  output logic flash_write,
  output logic erase_write_enabled_status
);

  fiap_pkg::fiap_state_t s;
  fiap_pkg::fiap_state_t next_s;

  logic [3:0] widx;
  logic mapped;
  logic wr;
  logic hb_wr;
  logic [31:0] rd_mux;
  logic unlock_load;
  logic unlock_done;
  logic op_load;
  logic [fiap_pkg::TMR_W-1:0] op_len;
  logic op_done;
  logic go_req;

  // address decode; writes are ignored while an array operation runs
  assign widx = paddr[5:2];
  assign mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) && (widx <= fiap_pkg::IDX_LAST);
  assign wr = psel && penable && pwrite && mapped && (s.st == fiap_pkg::FIAP_IDLE);
  assign hb_wr = wr && (widx == fiap_pkg::IDX_WORD0_HIGH);
  assign go_req = wr && (widx == fiap_pkg::IDX_CTRL) && pwdata[fiap_pkg::CTRL_GO_BIT];

  // read data selection, captured in the setup phase
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (widx)
      fiap_pkg::IDX_CTRL:
        rd_mux[7:0] = {s.en, s.mode, s.trig, s.go, 2'b00};
      fiap_pkg::IDX_OPTS:
        rd_mux[7:0] = {6'h00, s.tsel, s.clr};
      fiap_pkg::IDX_ADDR_LOW:
        rd_mux[7:0] = s.addr[7:0];
      fiap_pkg::IDX_ADDR_HIGH:
        rd_mux[7:0] = {2'b00, s.addr[13:8]};
      default:
        if (widx >= fiap_pkg::IDX_DATA && widx <= fiap_pkg::IDX_LAST)
          rd_mux[7:0] = s.dat[3'(widx - fiap_pkg::IDX_DATA)];
    endcase
    if (!mapped)
      rd_mux = 32'h0000_0000;
  end

  // operation length from mode and timing select
  always_comb
  begin
    if (s.mode == fiap_pkg::MODE_ERASE)
      op_len = s.tsel ? fiap_pkg::TMR_W'(ERASE_SLOW) : fiap_pkg::TMR_W'(ERASE_FAST);
    else
      op_len = s.tsel ? fiap_pkg::TMR_W'(WRITE_SLOW) : fiap_pkg::TMR_W'(WRITE_FAST);
  end

  // unlock window opens on trigger in unlock mode
  assign unlock_load = wr && (widx == fiap_pkg::IDX_CTRL) && pwdata[fiap_pkg::CTRL_TRIG_BIT] && !s.trig
                       && (pwdata[6:4] == fiap_pkg::MODE_UNLOCK);
  // start only when enabled and mode is erase or write
  assign op_load = s.go && (s.st == fiap_pkg::FIAP_IDLE) && s.en
                   && (s.mode == fiap_pkg::MODE_ERASE || s.mode == fiap_pkg::MODE_WRITE);

  fiap_timer #(.W(fiap_pkg::TMR_W)) unlock_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .load(unlock_load),
    .load_val(fiap_pkg::TMR_W'(fiap_pkg::UNLOCK_CYCLES)),
    .running(),
    .done(unlock_done)
  );

  fiap_timer #(.W(fiap_pkg::TMR_W)) op_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .load(op_load),
    .load_val(op_len),
    .running(),
    .done(op_done)
  );

  // next state of all registers
  always_comb
  begin
    next_s = s;
    next_s.clr = 1'b0;
    // the array names a buffer word and gets it one cycle later
    next_s.rd_data = s.wbuf[flash_buf_idx];
    if (psel && !penable)
      next_s.prdata = rd_mux;
    if (wr)
    begin
      case (widx)
        fiap_pkg::IDX_CTRL:
        begin
          // writing one to the enabled bit has no effect
          if (!pwdata[fiap_pkg::CTRL_EN_BIT])
            next_s.en = 1'b0;
          next_s.mode = pwdata[fiap_pkg::CTRL_MODE_LSB +: 3];
          if (unlock_load)
            next_s.trig = 1'b1;
          if (pwdata[fiap_pkg::CTRL_GO_BIT])
            next_s.go = 1'b1;
        end
        fiap_pkg::IDX_OPTS:
        begin
          next_s.tsel = pwdata[fiap_pkg::OPTS_TSEL_BIT];
          // buffer clear control empties buffer and tags
          if (pwdata[fiap_pkg::OPTS_CLR_BIT])
          begin
            next_s.clr = 1'b1;
            next_s.wbuf = '0;
            next_s.tags = '0;
          end
        end
        fiap_pkg::IDX_ADDR_LOW:
          next_s.addr[7:0] = pwdata[7:0];
        fiap_pkg::IDX_ADDR_HIGH:
          next_s.addr[13:8] = pwdata[5:0];
        default:
        begin
          // plain byte store into the data registers
          next_s.dat[3'(widx - fiap_pkg::IDX_DATA)] = pwdata[7:0];
          if (hb_wr)
          begin
            // load word and tag the address
            next_s.wbuf[s.addr[4:0]] = {pwdata[7:0], s.dat[0]};
            next_s.tags[s.addr[4:0]] = 1'b1;
            // hold at the last word of the page
            if (s.addr[4:0] != fiap_pkg::PAGE_LAST_WORD)
              next_s.addr = s.addr + 14'h0001;
          end
        end
      endcase
    end
    // window closes when the unlock timer runs out
    if (unlock_done)
      next_s.trig = 1'b0;
    // checked every cycle, so the six bytes may arrive in any order
    // pattern seen in time sets enabled, winning over a clear
    if (s.trig && next_s.dat[7:2] == fiap_pkg::UNLOCK_PATTERN)
      next_s.en = 1'b1;
    // refused start drops write initiate at once
    if (s.go && s.st == fiap_pkg::FIAP_IDLE && !op_load)
      next_s.go = 1'b0;
    if (op_load)
      next_s.st = (s.mode == fiap_pkg::MODE_ERASE) ? fiap_pkg::FIAP_ERASE : fiap_pkg::FIAP_WRITE;
    if (op_done)
    begin
      // completion clears initiate, buffer and tags
      next_s.st = fiap_pkg::FIAP_IDLE;
      next_s.go = 1'b0;
      next_s.wbuf = '0;
      next_s.tags = '0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= fiap_pkg::STATE_RESET;
    else
      s <= next_s;
  end

  // outputs to the bus and to the flash array
  assign prdata = s.prdata;
  // zero wait states: each access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign flash_buf_data = s.rd_data;
  // array erases only words whose tag is set
  assign flash_tags = s.tags;
  assign flash_page = s.addr[13:5];
  assign flash_erase = (s.st == fiap_pkg::FIAP_ERASE);
  assign flash_write = (s.st == fiap_pkg::FIAP_WRITE);
  assign erase_write_enabled_status = s.en;

  // checks on the design's own behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  low_byte_only_a: assert property (wr && widx == fiap_pkg::IDX_DATA |=> $stable(s.wbuf) && $stable(s.addr))
    else $error("low byte write disturbed buffer or address");

  high_byte_load_a: assert property (hb_wr |=> s.wbuf[$past(s.addr[4:0])] == {$past(pwdata[7:0]), $past(s.dat[0])})
    else $error("high byte write did not load buffer word");

  addr_advance_a: assert property (hb_wr && s.addr[4:0] != 5'h1f |=> s.addr == $past(s.addr) + 14'h0001)
    else $error("address did not advance after high byte write");

  page_stop_a: assert property (hb_wr && s.addr[4:0] == 5'h1f |=> s.addr == $past(s.addr))
    else $error("address moved past last page word");

  tag_set_a: assert property (hb_wr |=> s.tags[$past(s.addr[4:0])])
    else $error("written address not tagged");

  unlock_sets_a: assert property (s.trig && s.dat[7:2] == fiap_pkg::UNLOCK_PATTERN |=> s.en)
    else $error("correct pattern did not set enabled status");

  start_needs_en_a: assert property ($rose(flash_erase) || $rose(flash_write) |-> $past(s.en) && $past(s.go))
    else $error("array operation started without enable");

  mode_decode_a: assert property ($rose(flash_erase) |-> $past(s.mode) == 3'h1)
    else $error("erase started from wrong mode code");

  go_clear_a: assert property (op_done |=> !s.go && s.st == fiap_pkg::FIAP_IDLE && !flash_write)
    else $error("write initiate not cleared at completion");

  refused_go_a: assert property (s.go && !s.en && s.st == fiap_pkg::FIAP_IDLE |=> !s.go ##1 !flash_write)
    else $error("write initiate kept without enable");

  buf_cleared_a: assert property (op_done |=> s.wbuf == '0 && s.tags == '0)
    else $error("write buffer not cleared after operation");

  unlock_close_a: assert property (unlock_done |=> !s.trig)
    else $error("unlock trigger not cleared at timeout");

  // enabled can only rise inside an open unlock window
  en_from_window_a: assert property ($rose(s.en) |-> $past(s.trig))
    else $error("enabled status set outside an unlock window");

  // the window opens only from an unlock-mode trigger write
  window_open_a: assert property ($rose(s.trig) |-> $past(unlock_load))
    else $error("unlock window opened without trigger write");

  // the window stays open until the unlock timer runs out
  window_hold_a: assert property (s.trig && !unlock_done |=> s.trig)
    else $error("unlock window closed early");

  // the stored mode code is the one software wrote
  mode_store_a: assert property (wr && widx == fiap_pkg::IDX_CTRL
    |=> s.mode == $past(pwdata[fiap_pkg::CTRL_MODE_LSB +: 3]))
    else $error("mode field not stored as written");

  // an initiate with a reserved or read mode never reaches the array
  reserved_mode_a: assert property (s.go && s.st == fiap_pkg::FIAP_IDLE && s.mode != fiap_pkg::MODE_ERASE
    && s.mode != fiap_pkg::MODE_WRITE |=> !s.go && !flash_erase && !flash_write)
    else $error("operation started from a mode that is not erase or write");

  // a write level comes only from the write mode code
  write_decode_a: assert property ($rose(flash_write) |-> $past(s.mode) == fiap_pkg::MODE_WRITE)
    else $error("write started from wrong mode code");

  // an operation level stays up until its timer finishes
  op_level_hold_a: assert property ((flash_erase || flash_write) && !op_done |=> $stable(s.st))
    else $error("operation level dropped before completion");

  // initiate reads high for the whole operation
  go_busy_a: assert property (s.st != fiap_pkg::FIAP_IDLE && !op_done |=> s.go)
    else $error("write initiate dropped while operation runs");

  // page and tags must not move under a running operation
  op_target_stable_a: assert property ((flash_erase || flash_write) && !op_done
    |=> $stable(flash_tags) && $stable(flash_page))
    else $error("page or tags changed during operation");

  // bus writes during an operation are dropped
  busy_drop_a: assert property (psel && penable && pwrite && s.st != fiap_pkg::FIAP_IDLE
    |=> $stable(s.dat) && $stable(s.addr))
    else $error("register changed by a write during operation");

  // only tagging writes set new tag bits
  tag_source_a: assert property ((s.tags & ~$past(s.tags)) != '0 |-> $past(hb_wr))
    else $error("tag bit set without a high byte write");

  // only a high byte write gives a buffer word new content
  buf_source_a: assert property (s.wbuf != $past(s.wbuf) && s.wbuf != '0 |-> $past(hb_wr))
    else $error("buffer loaded without a high byte write");

  // a low byte write stores exactly the written byte
  low_store_a: assert property (wr && widx == fiap_pkg::IDX_DATA |=> s.dat[0] == $past(pwdata[7:0]))
    else $error("low byte not stored as written");

  // the data bytes above the word0 high byte store what was written
  pair_store_a: assert property (wr && widx > fiap_pkg::IDX_WORD0_HIGH
    |=> s.dat[3'($past(widx) - fiap_pkg::IDX_DATA)] == $past(pwdata[7:0]))
    else $error("data register byte not stored as written");

  // tagging keeps the address inside its page
  page_fixed_a: assert property (hb_wr |=> $stable(flash_page))
    else $error("address left its page");

  // a software clear of enabled holds when no window is open
  en_clear_a: assert property (wr && widx == fiap_pkg::IDX_CTRL && !pwdata[fiap_pkg::CTRL_EN_BIT] && !s.trig
    |=> !s.en)
    else $error("enabled status not cleared by software");

  // a buffer clear empties buffer and tags at once
  buf_clear_a: assert property (wr && widx == fiap_pkg::IDX_OPTS && pwdata[fiap_pkg::OPTS_CLR_BIT]
    |=> s.wbuf == '0 && s.tags == '0)
    else $error("buffer clear left data or tags");

  // main scenarios reached
  unlock_seen_c: cover property ($rose(s.en));
  erase_run_c: cover property ($rose(flash_erase) ##[1:1000] !flash_erase);
  write_run_c: cover property ($rose(flash_write));
  page_stop_c: cover property (hb_wr && s.addr[4:0] == 5'h1f);
  refused_go_c: cover property (s.go && !s.en && s.st == fiap_pkg::FIAP_IDLE);

endmodule

/* File: fiap_pkg.sv */
package fiap_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] OPTS_OFS = 12'h004;
  localparam logic [11:0] ADDR_LOW_OFS = 12'h008;
  localparam logic [11:0] ADDR_HIGH_OFS = 12'h00c;
  localparam logic [11:0] DATA_OFS = 12'h010;
  localparam logic [11:0] LAST_OFS = 12'h02c;

  // word indices (paddr[5:2]) of the same registers
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_OPTS = 4'h1;
  localparam logic [3:0] IDX_ADDR_LOW = 4'h2;
  localparam logic [3:0] IDX_ADDR_HIGH = 4'h3;
  localparam logic [3:0] IDX_DATA = 4'h4;
  localparam logic [3:0] IDX_WORD0_HIGH = 4'h5;
  localparam logic [3:0] IDX_LAST = 4'hb;

  // field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_TRIG_BIT = 3;
  localparam int CTRL_GO_BIT = 2;
  localparam int OPTS_TSEL_BIT = 1;
  localparam int OPTS_CLR_BIT = 0;
  localparam logic [4:0] PAGE_LAST_WORD = 5'h1f;

  // operation mode codes
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  // unlock pattern, word3 high down to word1 low
  localparam logic [5:0][7:0] UNLOCK_PATTERN = {8'h40, 8'hc3, 8'h09, 8'h0d, 8'h04, 8'h00};

  // timing: clock period and array operation times
  localparam int CLK_PERIOD_NS = 4;
  localparam int ERASE_FAST_NS = 3200000;
  localparam int ERASE_SLOW_NS = 3700000;
  localparam int WRITE_FAST_NS = 2200000;
  localparam int WRITE_SLOW_NS = 3000000;
  localparam int ERASE_FAST_CYCLES = ERASE_FAST_NS / CLK_PERIOD_NS;
  localparam int ERASE_SLOW_CYCLES = ERASE_SLOW_NS / CLK_PERIOD_NS;
  localparam int WRITE_FAST_CYCLES = WRITE_FAST_NS / CLK_PERIOD_NS;
  localparam int WRITE_SLOW_CYCLES = WRITE_SLOW_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_CYCLES = 1024;
  localparam int TMR_W = 20;

  typedef enum logic [2:0] {
    FIAP_IDLE = 3'b001,
    FIAP_ERASE = 3'b010,
    FIAP_WRITE = 3'b100
  } fiap_op_t;

  typedef struct packed {
    fiap_op_t st;
    logic en;
    logic [2:0] mode;
    logic trig;
    logic go;
    logic tsel;
    logic clr;
    logic [13:0] addr;
    logic [7:0][7:0] dat;
    logic [31:0][15:0] wbuf;
    logic [31:0] tags;
    logic [31:0] prdata;
    logic [15:0] rd_data;
  } fiap_state_t;

  localparam fiap_state_t STATE_RESET = '{st: FIAP_IDLE, default: '0};

endpackage

/* File: fiap_timer.sv */
`timescale 1ns/1ps

// down counter: load starts it, done pulses on the last cycle
module fiap_timer #(
  parameter int W = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic running,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } fiap_tmr_t;

  fiap_tmr_t s;
  fiap_tmr_t next_s;

  // count down to zero, reload on request
  always_comb
  begin
    next_s = s;
    if (load)
      next_s.cnt = load_val;
    else if (s.cnt != '0)
      next_s.cnt = s.cnt - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign running = (s.cnt != '0);
  assign done = (s.cnt == {{(W-1){1'b0}}, 1'b1}) && !load;

endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, flash_tags;
  logic [4:0] flash_buf_idx;
  logic [15:0] flash_buf_data;
  logic [8:0] flash_page;
  logic flash_erase, flash_write, erase_write_enabled_status, rerr;
  int n_fail, tests_run, n;

  // short op lengths keep the run brief
  fiap_core #(.ERASE_FAST(20), .ERASE_SLOW(25), .WRITE_FAST(15), .WRITE_SLOW(18)) u_fiap_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_buf_idx(flash_buf_idx), .flash_buf_data(flash_buf_data), .flash_tags(flash_tags),
    .flash_page(flash_page), .flash_erase(flash_erase), .flash_write(flash_write),
    .erase_write_enabled_status(erase_write_enabled_status));

  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, request held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask

  task automatic buf_chk(input logic [4:0] i, input logic [15:0] exp);
    flash_buf_idx <= i;
    repeat (2) @(posedge pclk);
    chk({16'h0, flash_buf_data}, {16'h0, exp});
  endtask

  // waits bounded for the op level, returns cycles spent
  task automatic wait_op(input logic want);
    n = 0;
    while (((flash_erase | flash_write) !== want) && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic give_verdict;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end

  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    flash_buf_idx = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int k = 0; k < 8; k++) rd(fiap_pkg::DATA_OFS + 12'(4 * k), 32'h0);
    for (int k = 2; k < 8; k++)
    begin
      wr(fiap_pkg::DATA_OFS + 12'(4 * k), 8'ha0 + 8'(k));
      rd(fiap_pkg::DATA_OFS + 12'(4 * k), 32'ha0 + k);
    end
    apb(1'b0, 12'h030, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    // go without enable must not start an erase
    wr(fiap_pkg::CTRL_OFS, 8'h14);
    repeat (4) @(posedge pclk);
    chk({31'h0, flash_erase}, 32'h0);
    // unlock: mode 110 plus trigger, then the six-byte pattern
    wr(fiap_pkg::CTRL_OFS, 8'h68);
    wr(12'h018, 8'h00);
    wr(12'h01c, 8'h04);
    wr(12'h020, 8'h0d);
    wr(12'h024, 8'h09);
    wr(12'h028, 8'hc3);
    wr(12'h02c, 8'h40);
    repeat (2) @(posedge pclk);
    chk({31'h0, erase_write_enabled_status}, 32'h1);
    rd(fiap_pkg::CTRL_OFS, 32'h000000e8);
    // page erase: tag the two last words of page 8
    wr(fiap_pkg::CTRL_OFS, 8'h90);
    wr(fiap_pkg::ADDR_HIGH_OFS, 8'h01);
    wr(fiap_pkg::ADDR_LOW_OFS, 8'h1e);
    wr(fiap_pkg::DATA_OFS + 12'h4, 8'hff);
    wr(fiap_pkg::DATA_OFS + 12'h4, 8'hff);
    wr(fiap_pkg::DATA_OFS + 12'h4, 8'hff);
    rd(fiap_pkg::ADDR_LOW_OFS, 32'h1f);
    rd(fiap_pkg::ADDR_HIGH_OFS, 32'h01);
    chk(flash_tags, 32'hc0000000);
    buf_chk(5'd31, 16'hff00);
    wr(fiap_pkg::CTRL_OFS, 8'h94);
    wait_op(1'b1);
    chk(n, 1);
    chk({31'h0, flash_erase}, 32'h1);
    chk({23'h0, flash_page}, 32'h8);
    chk(flash_tags, 32'hc0000000);
    wait_op(1'b0);
    chk(n, 20);
    chk(flash_tags, 32'h0);
    buf_chk(5'd31, 16'h0000);
    rd(fiap_pkg::CTRL_OFS, 32'h00000098);
    chk(rdat & 32'hf4, 32'h90);
    // tag again and erase again, as after a failed blank check
    wr(fiap_pkg::ADDR_LOW_OFS, 8'h00);
    wr(fiap_pkg::DATA_OFS + 12'h4, 8'hff);
    chk(flash_tags, 32'h00000001);
    wr(fiap_pkg::CTRL_OFS, 8'h94);
    wait_op(1'b1);
    chk({31'h0, flash_erase}, 32'h1);
    wait_op(1'b0);
    chk(flash_tags, 32'h0);
    // write mode: low byte alone leaves the buffer
    wr(fiap_pkg::CTRL_OFS, 8'h80);
    wr(fiap_pkg::ADDR_LOW_OFS, 8'h1e);
    wr(fiap_pkg::DATA_OFS, 8'h34);
    buf_chk(5'd30, 16'h0000);
    wr(fiap_pkg::DATA_OFS + 12'h4, 8'h12);
    buf_chk(5'd30, 16'h1234);
    rd(fiap_pkg::ADDR_LOW_OFS, 32'h1f);
    wr(fiap_pkg::DATA_OFS, 8'h78);
    wr(fiap_pkg::DATA_OFS + 12'h4, 8'h56);
    buf_chk(5'd31, 16'h5678);
    wr(fiap_pkg::DATA_OFS + 12'h4, 8'h9a);
    buf_chk(5'd31, 16'h9a78);
    rd(fiap_pkg::ADDR_LOW_OFS, 32'h1f);
    wr(fiap_pkg::CTRL_OFS, 8'h84);
    wait_op(1'b1);
    chk({31'h0, flash_write}, 32'h1);
    chk(n, 1);
    wait_op(1'b0);
    chk(n, 15);
    buf_chk(5'd30, 16'h0000);
    buf_chk(5'd31, 16'h0000);
    rd(fiap_pkg::CTRL_OFS, 32'h00000088);
    chk(rdat & 32'hf4, 32'h80);
    // software buffer clear after a reload
    wr(fiap_pkg::ADDR_LOW_OFS, 8'h05);
    wr(fiap_pkg::DATA_OFS + 12'h4, 8'h77);
    buf_chk(5'd5, 16'h7778);
    wr(fiap_pkg::OPTS_OFS, 8'h01);
    buf_chk(5'd5, 16'h0000);
    // the unlock window closes by itself; enabled stays set
    repeat (1024) @(posedge pclk);
    rd(fiap_pkg::CTRL_OFS, 32'h00000080);
    // disable, then go must stay idle
    wr(fiap_pkg::CTRL_OFS, 8'h04);
    repeat (4) @(posedge pclk);
    chk({31'h0, erase_write_enabled_status}, 32'h0);
    chk({30'h0, flash_write, flash_erase}, 32'h0);
    give_verdict();
  end
endmodule
